// File: rcc_pkg.sv
// rcc_pkg: constants, codes and carrier types of the relay closure counter
// assumes a single 125 MHz core clock shared by every user of the package
package rcc_pkg;

	// ==========================================================
	// channel space
	localparam int RCC_SLOTS = 2;
	localparam int RCC_CH_W = 6;
	localparam int RCC_IDX_W = 7;
	localparam int RCC_NCHAN = 128;
	localparam logic [RCC_IDX_W-1:0] RCC_IDX_LAST = 7'h7f;
	localparam logic [RCC_IDX_W-1:0] RCC_IDX_FIRST = 7'h00;
	localparam int RCC_CNT_W = 32;
	localparam int RCC_MODEL_W = 16;

	// ==========================================================
	// update interval, in minutes
	localparam int RCC_IVL_W = 11;
	localparam logic [RCC_IVL_W-1:0] RCC_IVL_MIN = 11'h00a;
	localparam logic [RCC_IVL_W-1:0] RCC_IVL_MAX = 11'h5a0;
	localparam logic [RCC_IVL_W-1:0] RCC_IVL_RESET = 11'h00f;

	// ==========================================================
	// timing
	localparam longint unsigned RCC_CLK_HZ = 125_000_000;
	localparam longint unsigned RCC_MINUTE_S = 60;
	localparam longint unsigned RCC_MINUTE_CYCLES = RCC_CLK_HZ * RCC_MINUTE_S;
	localparam int RCC_TICK_W = 33;

	// ==========================================================
	// answer codes
	// empty slot code is arbitrary
	localparam logic [RCC_MODEL_W-1:0] RCC_MODEL_NONE = 16'hffff;
	localparam logic [RCC_CNT_W-1:0] RCC_LIST_END = 32'hffffffff;
	localparam logic [1:0] RCC_SLOT1 = 2'h1;
	localparam logic [1:0] RCC_SLOT2 = 2'h2;

	// ==========================================================
	// host commands
	typedef enum logic [2:0] {
		rcc_op_count_query = 3'h0,
		rcc_op_interval_set = 3'h1,
		rcc_op_interval_query = 3'h2,
		rcc_op_state_query = 3'h3,
		rcc_op_closed_single_query = 3'h4,
		rcc_op_closed_multi_query = 3'h5,
		rcc_op_installed_option_query = 3'h6
	} rcc_op_t;

	typedef struct packed {
		rcc_op_t op;
		logic [RCC_IDX_W-1:0] first;
		logic [RCC_IDX_W-1:0] last;
		logic [RCC_IVL_W-1:0] value;
	} rcc_cmd_t;

	typedef struct packed {
		logic close;
		logic [RCC_IDX_W-1:0] idx;
	} rcc_rly_t;

	typedef struct packed {
		logic [RCC_CNT_W-1:0] data;
		logic last;
	} rcc_rsp_t;

endpackage

// File: rcc_count_ram.sv
// rcc_count_ram: working memory of closure totals, one word per channel
// assumes one user; read data is registered and follows addr one cycle late
`timescale 1ns/1ns
module rcc_count_ram #(
	parameter int DEPTH = 128,
	parameter int AW = 7,
	parameter int DW = 32
) (
	// clock
	input wire logic core_clk,
	// access
	input wire logic [AW-1:0] addr,
	input wire logic we,
	input wire logic [DW-1:0] wdata,
	output logic [DW-1:0] rdata
);

	// ==========================================================
	// checks
	if (DEPTH < 1 || DEPTH > (1 << AW)) begin : g_bad_depth
		$error("rcc_count_ram: depth does not fit the address width");
	end

	// ==========================================================
	// storage
	// contents are not cleared: totals survive only through the nv copy
	logic [DW-1:0] mem [DEPTH];

	always_ff @(posedge core_clk) begin
		if (we) begin
			mem[addr] <= wdata;
		end
		rdata <= mem[addr];
	end

endmodule

// File: rcc_interval_timer.sv
// rcc_interval_timer: minute ticks from core_clk, expiry after a set number of minutes
// assumes interval is held stable by its owner between changes
`timescale 1ns/1ns
module rcc_interval_timer
	import rcc_pkg::*;
#(
	parameter longint unsigned MINUTE_CYCLES = RCC_MINUTE_CYCLES
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic sys_rst,
	// control
	input wire logic restart,
	input wire logic [RCC_IVL_W-1:0] interval,
	// event
	output logic expire
);

	// ==========================================================
	// checks
	if (MINUTE_CYCLES < 1 || MINUTE_CYCLES > (64'h1 << RCC_TICK_W)) begin : g_bad_minute
		$error("rcc_interval_timer: minute length does not fit the tick counter");
	end

	localparam logic [RCC_TICK_W-1:0] TICK_TOP = RCC_TICK_W'(MINUTE_CYCLES - 1);

	// ==========================================================
	// state
	typedef struct packed {
		logic [RCC_TICK_W-1:0] cyc;
		logic [RCC_IVL_W-1:0] minutes;
		logic expire;
	} rcc_tmr_t;

	rcc_tmr_t s;
	rcc_tmr_t next_s;

	always_comb begin
		next_s = s;
		next_s.expire = 1'b0;
		if (restart) begin
			next_s.cyc = '0;
			next_s.minutes = '0;
		end else if (s.cyc == TICK_TOP) begin
			next_s.cyc = '0;
			// >= also catches an interval lowered below the minutes already counted
			if (s.minutes + 11'h001 >= interval) begin
				next_s.minutes = '0;
				next_s.expire = 1'b1;
			end else begin
				next_s.minutes = s.minutes + 11'h001;
			end
		end else begin
			next_s.cyc = s.cyc + 33'h000000001;
		end
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign expire = s.expire;

endmodule

// File: rcc_relay_closure_counter.sv
// rcc_relay_closure_counter: relay state, closure totals, nv commits and host queries
// assumes commands arrive already parsed, and relay requests from every source share one port
`timescale 1ns/1ns

module rcc_relay_closure_counter
	import rcc_pkg::*;
#(
	parameter longint unsigned MINUTE_CYCLES = RCC_MINUTE_CYCLES
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic sys_rst,
	// relay requests, from remote, panel and scan alike
	input wire logic rly_valid,
	output logic rly_ready,
	input wire rcc_rly_t rly,
	// host commands
	input wire logic cmd_valid,
	output logic cmd_ready,
	input wire rcc_cmd_t cmd,
	output logic cmd_err,
	// host answers
	output logic rsp_valid,
	input wire logic rsp_ready,
	output rcc_rsp_t rsp,
	// card nonvolatile memory
	output logic nv_valid,
	input wire logic nv_ready,
	output logic [RCC_IDX_W-1:0] nv_addr,
	output logic [RCC_CNT_W-1:0] nv_data,
	// card information
	input wire logic [RCC_SLOTS-1:0] slot_present,
	input wire logic [RCC_SLOTS-1:0][RCC_MODEL_W-1:0] slot_model,
	input wire logic [RCC_NCHAN-1:0] meas_mask,
	// relay drive
	output logic [RCC_NCHAN-1:0] relay_state
);

	// ==========================================================
	// state
	typedef enum {
		st_idle,
		st_inc_rd,
		st_inc_wr,
		st_cm_rd,
		st_cm_lat,
		st_cm_wr,
		st_cq_rd,
		st_cq_lat,
		st_cq_out,
		st_sq_out,
		st_ls_scan,
		st_ls_out,
		st_opt_out,
		st_ivl_out
	} rcc_state_t;

	typedef struct packed {
		rcc_state_t st;
		logic [RCC_NCHAN-1:0] relay;
		logic [RCC_IVL_W-1:0] ivl;
		logic pend;
		logic report;
		logic multi;
		logic [RCC_IDX_W-1:0] idx;
		logic [RCC_IDX_W-1:0] first;
		logic [RCC_IDX_W-1:0] end_idx;
		rcc_rsp_t rsp;
		logic cmd_err;
		logic [RCC_CNT_W-1:0] nv_data;
	} rcc_main_t;

	rcc_main_t s;
	rcc_main_t next_s;

	logic [RCC_CNT_W-1:0] ram_rdata;
	logic ram_we;
	logic [RCC_CNT_W-1:0] ram_wdata;
	logic expire;
	logic timer_restart;
	logic [RCC_IDX_W-1:0] next_idx;

	// ==========================================================
	// helpers
	function automatic logic [RCC_CNT_W-1:0] chan_code(input logic [RCC_IDX_W-1:0] i);
		logic [1:0] slot;
		slot = i[RCC_IDX_W-1] ? RCC_SLOT2 : RCC_SLOT1;
		chan_code = {16'h0000, 6'h00, slot, 2'h0, i[RCC_CH_W-1:0]};
	endfunction

	function automatic logic [RCC_CNT_W-1:0] opt_code(input logic sel,
			input logic [RCC_SLOTS-1:0] present,
			input logic [RCC_SLOTS-1:0][RCC_MODEL_W-1:0] model);
		opt_code = {16'h0000, present[sel] ? model[sel] : RCC_MODEL_NONE};
	endfunction

	// ==========================================================
	// sub blocks
	rcc_count_ram #(
		.DEPTH(RCC_NCHAN),
		.AW(RCC_IDX_W),
		.DW(RCC_CNT_W)
	) u_ram (
		.core_clk(core_clk),
		.addr(s.idx),
		.we(ram_we),
		.wdata(ram_wdata),
		.rdata(ram_rdata)
	);

	rcc_interval_timer #(
		.MINUTE_CYCLES(MINUTE_CYCLES)
	) u_timer (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.restart(timer_restart),
		.interval(s.ivl),
		.expire(expire)
	);

	// ==========================================================
	// handshakes
	// a due commit goes first, then relay requests, then host commands
	assign rly_ready = (s.st == st_idle) && !s.pend;
	assign cmd_ready = (s.st == st_idle) && !s.pend && !rly_valid;
	assign rsp_valid = (s.st == st_cq_out) || (s.st == st_sq_out) || (s.st == st_ls_out) ||
		(s.st == st_opt_out) || (s.st == st_ivl_out);
	assign nv_valid = (s.st == st_cm_wr);
	assign ram_we = (s.st == st_inc_wr);
	assign ram_wdata = ram_rdata + 32'h00000001;
	assign timer_restart = (s.st == st_cm_wr) && nv_ready && (s.idx == RCC_IDX_LAST);
	assign next_idx = s.idx + 7'h01;

	// ==========================================================
	// control
	always_comb begin
		next_s = s;
		next_s.cmd_err = 1'b0;
		// expiry while the flag is taken is kept: the set wins
		next_s.pend = s.pend || expire;
		unique case (s.st)
			st_idle: begin
				if (s.pend) begin
					next_s.pend = expire;
					next_s.report = 1'b0;
					next_s.idx = RCC_IDX_FIRST;
					next_s.st = st_cm_rd;
				end else if (rly_valid) begin
					if (!rly.close) begin
						next_s.relay[rly.idx] = 1'b0;
					end else if (!s.relay[rly.idx]) begin
						next_s.relay[rly.idx] = 1'b1;
						next_s.idx = rly.idx;
						next_s.st = st_inc_rd;
					end
					// a close of a closed relay only holds it
				end else if (cmd_valid) begin
					next_s.first = cmd.first;
					next_s.end_idx = (cmd.last < cmd.first) ? cmd.first : cmd.last;
					unique case (cmd.op)
						rcc_op_count_query: begin
							next_s.report = 1'b1;
							next_s.idx = RCC_IDX_FIRST;
							next_s.st = st_cm_rd;
						end
						rcc_op_interval_set: begin
							if (cmd.value >= RCC_IVL_MIN && cmd.value <= RCC_IVL_MAX) begin
								next_s.ivl = cmd.value;
							end else begin
								next_s.cmd_err = 1'b1;
							end
						end
						rcc_op_interval_query: begin
							next_s.rsp = '{data: {21'h000000, s.ivl}, last: 1'b1};
							next_s.st = st_ivl_out;
						end
						rcc_op_state_query: begin
							next_s.idx = cmd.first;
							next_s.rsp = '{data: {31'h00000000, s.relay[cmd.first]},
								last: (cmd.last <= cmd.first)};
							next_s.st = st_sq_out;
						end
						rcc_op_closed_single_query, rcc_op_closed_multi_query: begin
							next_s.multi = (cmd.op == rcc_op_closed_multi_query);
							next_s.idx = RCC_IDX_FIRST;
							next_s.st = st_ls_scan;
						end
						rcc_op_installed_option_query: begin
							next_s.idx = RCC_IDX_FIRST;
							next_s.rsp = '{data: opt_code(1'b0, slot_present, slot_model),
								last: 1'b0};
							next_s.st = st_opt_out;
						end
						default: begin
							next_s.cmd_err = 1'b1;
						end
					endcase
				end
			end
			st_inc_rd: begin
				next_s.st = st_inc_wr;
			end
			st_inc_wr: begin
				next_s.st = st_idle;
			end
			st_cm_rd: begin
				next_s.st = st_cm_lat;
			end
			st_cm_lat: begin
				next_s.nv_data = ram_rdata;
				next_s.st = st_cm_wr;
			end
			st_cm_wr: begin
				if (nv_ready) begin
					if (s.idx != RCC_IDX_LAST) begin
						next_s.idx = next_idx;
						next_s.st = st_cm_rd;
					end else if (s.report) begin
						next_s.idx = s.first;
						next_s.st = st_cq_rd;
					end else begin
						next_s.st = st_idle;
					end
				end
			end
			st_cq_rd: begin
				next_s.st = st_cq_lat;
			end
			st_cq_lat: begin
				next_s.rsp = '{data: ram_rdata, last: (s.idx == s.end_idx)};
				next_s.st = st_cq_out;
			end
			st_cq_out: begin
				if (rsp_ready) begin
					if (s.rsp.last) begin
						next_s.st = st_idle;
					end else begin
						next_s.idx = next_idx;
						next_s.st = st_cq_rd;
					end
				end
			end
			st_sq_out: begin
				if (rsp_ready) begin
					if (s.rsp.last) begin
						next_s.st = st_idle;
					end else begin
						next_s.idx = next_idx;
						next_s.rsp = '{data: {31'h00000000, s.relay[next_idx]},
							last: (next_idx == s.end_idx)};
					end
				end
			end
			st_ls_scan: begin
				// one channel a cycle: a full list walk costs 128 cycles plus answers
				if (s.relay[s.idx] && (s.multi || meas_mask[s.idx])) begin
					next_s.rsp = '{data: chan_code(s.idx), last: 1'b0};
					next_s.st = st_ls_out;
				end else if (s.idx == RCC_IDX_LAST) begin
					next_s.rsp = '{data: RCC_LIST_END, last: 1'b1};
					next_s.st = st_ls_out;
				end else begin
					next_s.idx = next_idx;
				end
			end
			st_ls_out: begin
				if (rsp_ready) begin
					if (s.rsp.last) begin
						next_s.st = st_idle;
					end else if (s.idx == RCC_IDX_LAST) begin
						next_s.rsp = '{data: RCC_LIST_END, last: 1'b1};
					end else begin
						next_s.idx = next_idx;
						next_s.st = st_ls_scan;
					end
				end
			end
			st_opt_out: begin
				if (rsp_ready) begin
					if (s.rsp.last) begin
						next_s.st = st_idle;
					end else begin
						next_s.rsp = '{data: opt_code(1'b1, slot_present, slot_model),
							last: 1'b1};
					end
				end
			end
			st_ivl_out: begin
				if (rsp_ready) begin
					next_s.st = st_idle;
				end
			end
		endcase
	end

	// ==========================================================
	// registers
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			s <= '{st: st_idle, ivl: RCC_IVL_RESET, default: '0};
		end else begin
			s <= next_s;
		end
	end

	// ==========================================================
	// outputs
	assign rsp = s.rsp;
	assign cmd_err = s.cmd_err;
	assign nv_addr = s.idx;
	assign nv_data = s.nv_data;
	assign relay_state = s.relay;

endmodule

// File: rcc_relay_closure_counter_properties.sv
// rcc_chk: port checker of the relay closure counter
// assumes one clock domain and binding to the top module
`timescale 1ns/1ns
module rcc_chk
	import rcc_pkg::*;
(
	// clock and reset
	input wire logic core_clk,
	input wire logic sys_rst,
	// relay side
	input wire logic rly_valid,
	input wire logic rly_ready,
	input wire rcc_rly_t rly,
	// commands and answers
	input wire logic cmd_valid,
	input wire logic cmd_ready,
	input wire rcc_cmd_t cmd,
	input wire logic cmd_err,
	input wire logic rsp_valid,
	input wire logic rsp_ready,
	input wire rcc_rsp_t rsp,
	// nv memory
	input wire logic nv_valid,
	input wire logic nv_ready,
	input wire logic [RCC_IDX_W-1:0] nv_addr,
	// relay drive
	input wire logic [RCC_NCHAN-1:0] relay_state
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	wire logic rtk = rly_valid && rly_ready;
	wire logic ctk = cmd_valid && cmd_ready;
	wire logic bad = cmd.value < RCC_IVL_MIN || cmd.value > RCC_IVL_MAX;
	// ==========================================================
	// relays
	property p_rly_close;
		rtk && rly.close |=> relay_state[$past(rly.idx)];
	endproperty
	a_rly_close: assert property (p_rly_close) else $error("close not applied");
	property p_rly_open;
		rtk && !rly.close |=> !relay_state[$past(rly.idx)];
	endproperty
	a_rly_open: assert property (p_rly_open) else $error("open not applied");
	property p_rly_count;
		rtk && rly.close && !relay_state[rly.idx] |=> !rly_ready [*2];
	endproperty
	a_rly_count: assert property (p_rly_count) else $error("no count update");
	property p_rly_again;
		rtk && rly.close && relay_state[rly.idx] |=> $stable(relay_state);
	endproperty
	a_rly_again: assert property (p_rly_again) else $error("reclose changed");
	// ==========================================================
	// commands, answers and nv writes
	property p_ivl_err;
		ctk && cmd.op == rcc_op_interval_set && bad |=> cmd_err;
	endproperty
	a_ivl_err: assert property (p_ivl_err) else $error("bad interval taken");
	property p_ivl_ok;
		ctk && cmd.op == rcc_op_interval_set && !bad |=> !cmd_err;
	endproperty
	a_ivl_ok: assert property (p_ivl_ok) else $error("good interval refused");
	property p_ivl_q;
		ctk && cmd.op == rcc_op_interval_query |=> rsp_valid && rsp.last;
	endproperty
	a_ivl_q: assert property (p_ivl_q) else $error("interval answer late");
	property p_state;
		ctk && cmd.op == rcc_op_state_query
			|=> rsp_valid && rsp.data == {31'h0, $past(relay_state[cmd.first])};
	endproperty
	a_state: assert property (p_state) else $error("state answer wrong");
	property p_cq_commit;
		ctk && cmd.op == rcc_op_count_query |-> ##[1:6] nv_valid && nv_addr == RCC_IDX_FIRST;
	endproperty
	a_cq_commit: assert property (p_cq_commit) else $error("query did not commit");
	property p_nv_hold;
		nv_valid && !nv_ready |=> nv_valid && $stable(nv_addr);
	endproperty
	a_nv_hold: assert property (p_nv_hold) else $error("nv write dropped");
	property p_rsp_hold;
		rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp.last);
	endproperty
	a_rsp_hold: assert property (p_rsp_hold) else $error("answer dropped");
endmodule

bind rcc_relay_closure_counter rcc_chk i_chk (.core_clk(core_clk), .sys_rst(sys_rst),
	.rly_valid(rly_valid), .rly_ready(rly_ready), .rly(rly), .cmd_valid(cmd_valid),
	.cmd_ready(cmd_ready), .cmd(cmd), .cmd_err(cmd_err), .rsp_valid(rsp_valid),
	.rsp_ready(rsp_ready), .rsp(rsp), .nv_valid(nv_valid), .nv_ready(nv_ready),
	.nv_addr(nv_addr), .relay_state(relay_state));

// File: rcc_nv_card.sv
// rcc_nv_card: card nonvolatile memory model, counts and orders writes
// assumes nv_valid and its address held until taken
`timescale 1ns/1ns
module rcc_nv_card
	import rcc_pkg::*;
(
	// clock
	input wire logic core_clk,
	// write port
	input wire logic nv_valid,
	output logic nv_ready,
	input wire logic [RCC_IDX_W-1:0] nv_addr,
	input wire logic [RCC_CNT_W-1:0] nv_data,
	// pace
	input wire logic slow
);
	logic [1:0] cnt = 2'h0;
	logic [RCC_IDX_W-1:0] exp_addr = 7'h00;
	int writes = 0;
	int bad = 0;
	// a slow card is ready one cycle in four, as a busy eeprom would be
	assign nv_ready = !slow || cnt == 2'h3;
	always @(posedge core_clk) begin
		cnt <= cnt + 2'h1;
		if (nv_valid && nv_ready) begin
			writes <= writes + 1;
			exp_addr <= nv_addr + 7'h01;
			if (nv_addr !== exp_addr) begin
				bad <= bad + 1;
			end
		end
	end
endmodule

// File: test_relay_closure_counter.sv
// test_relay_closure_counter: scenario bench of the relay closure counter
// assumes a 64-cycle minute, so a 10-minute interval outlasts one full commit
`timescale 1ns/1ns
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin error_cnt++; \
	$display("mismatch %s exp %0h got %0h", n, e, s); end end
module test_relay_closure_counter
	import rcc_pkg::*;
;
	logic core_clk, sys_rst, rly_valid, rly_ready, cmd_valid, cmd_ready, cmd_err;
	logic rsp_valid, rsp_ready, nv_valid, nv_ready, slow;
	rcc_rly_t rly;
	rcc_cmd_t cmd;
	rcc_rsp_t rsp;
	logic [RCC_IDX_W-1:0] nv_addr;
	logic [RCC_CNT_W-1:0] nv_data;
	logic [RCC_SLOTS-1:0] slot_present;
	logic [RCC_SLOTS-1:0][RCC_MODEL_W-1:0] slot_model;
	logic [RCC_NCHAN-1:0] meas_mask, relay_state;
	int error_cnt = 0;
	int compares = 0;
	always #4 core_clk = !core_clk;
	rcc_relay_closure_counter #(.MINUTE_CYCLES(64)) i_dut (.core_clk(core_clk),
		.sys_rst(sys_rst), .rly_valid(rly_valid), .rly_ready(rly_ready), .rly(rly),
		.cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd(cmd), .cmd_err(cmd_err),
		.rsp_valid(rsp_valid), .rsp_ready(rsp_ready), .rsp(rsp), .nv_valid(nv_valid),
		.nv_ready(nv_ready), .nv_addr(nv_addr), .nv_data(nv_data),
		.slot_present(slot_present), .slot_model(slot_model), .meas_mask(meas_mask),
		.relay_state(relay_state));
	rcc_nv_card i_nv (.core_clk(core_clk), .nv_valid(nv_valid), .nv_ready(nv_ready),
		.nv_addr(nv_addr), .nv_data(nv_data), .slow(slow));
	// ==========================================================
	// drivers
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	task automatic relay(input logic cl, input logic [6:0] idx);
		int k;
		rly = '{close: cl, idx: idx};
		rly_valid = 1'b1;
		for (k = 0; k < 2000 && !rly_ready; k++) tick(1);
		tick(1);
		rly_valid = 1'b0;
		// one idle edge, so a following call never raises valid in this step
		tick(1);
	endtask
	task automatic send(input rcc_op_t op, input logic [6:0] f, input logic [6:0] l,
		input logic [10:0] v);
		int k;
		cmd = '{op: op, first: f, last: l, value: v};
		cmd_valid = 1'b1;
		for (k = 0; k < 2000 && !cmd_ready; k++) tick(1);
		tick(1);
		cmd_valid = 1'b0;
	endtask
	// stalls each word one cycle; dc skips totals that start unknown
	task automatic get(input logic [31:0] d, input logic l, input logic dc);
		int k;
		for (k = 0; k < 3000 && !rsp_valid; k++) tick(1);
		tick(1);
		`CHK("rsp", {d, l}, {(dc ? d : rsp.data), rsp.last})
		rsp_ready = 1'b1;
		tick(1);
		rsp_ready = 1'b0;
	endtask
	// ==========================================================
	// scenarios
	task automatic t_interval();
		logic [10:0] v [4] = '{11'h009, 11'h5a1, 11'h5a0, 11'h00a};
		logic [10:0] q [4] = '{11'h00f, 11'h00f, 11'h5a0, 11'h00a};
		int i;
		send(rcc_op_interval_query, 7'h00, 7'h00, 11'h000);
		get(32'h0000000f, 1'b1, 1'b0);
		for (i = 0; i < 4; i++) begin
			send(rcc_op_interval_set, 7'h00, 7'h00, v[i]);
			// cmd_err stands for one cycle only, right after the take
			`CHK("err", (i < 2), cmd_err)
			tick(1);
			send(rcc_op_interval_query, 7'h00, 7'h00, 11'h000);
			get({21'h0, q[i]}, 1'b1, 1'b0);
		end
	endtask
	task automatic t_relay();
		relay(1'b1, 7'h03);
		relay(1'b1, 7'h03);
		relay(1'b0, 7'h04);
		relay(1'b1, 7'h45);
		`CHK("rs", 2'h3, {relay_state[7'h45], relay_state[3]})
		send(rcc_op_state_query, 7'h03, 7'h05, 11'h000);
		get(32'h00000001, 1'b0, 1'b0);
		get(32'h00000000, 1'b0, 1'b0);
		get(32'h00000000, 1'b1, 1'b0);
	endtask
	task automatic t_lists();
		send(rcc_op_closed_single_query, 7'h00, 7'h00, 11'h000);
		get(32'h00000103, 1'b0, 1'b0);
		get(32'hffffffff, 1'b1, 1'b0);
		send(rcc_op_closed_multi_query, 7'h00, 7'h00, 11'h000);
		get(32'h00000103, 1'b0, 1'b0);
		get(32'h00000205, 1'b0, 1'b0);
		get(32'hffffffff, 1'b1, 1'b0);
	endtask
	task automatic t_option();
		send(rcc_op_installed_option_query, 7'h00, 7'h00, 11'h000);
		get(32'h00001234, 1'b0, 1'b0);
		get(32'h0000ffff, 1'b1, 1'b0);
		slot_present = 2'h2;
		send(rcc_op_installed_option_query, 7'h00, 7'h00, 11'h000);
		get(32'h0000ffff, 1'b0, 1'b0);
		get(32'h00005678, 1'b1, 1'b0);
	endtask
	// slow card first, then the 640-cycle interval on a prompt card
	task automatic t_count();
		int w;
		int k;
		slow = 1'b1;
		w = i_nv.writes;
		send(rcc_op_count_query, 7'h03, 7'h04, 11'h000);
		get(32'h00000000, 1'b0, 1'b1);
		get(32'h00000000, 1'b1, 1'b1);
		`CHK("nvw", 1'b1, (i_nv.writes - w >= 128))
		`CHK("nvo", 0, i_nv.bad)
		slow = 1'b0;
		// an expiry seen during the slow commit is kept, so one more commit may follow
		for (k = 0; k < 2000 && !rly_ready; k++) tick(1);
		w = i_nv.writes;
		tick(600);
		`CHK("early", w, i_nv.writes)
		tick(450);
		`CHK("tmr", 1'b1, (i_nv.writes - w >= 128))
	endtask
	task automatic wrap_up();
		$display("compares %0d error_cnt %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	// ==========================================================
	// sequence and watchdog
	initial begin
		core_clk = 1'b0;
		sys_rst = 1'b1;
		rly_valid = 1'b0;
		cmd_valid = 1'b0;
		rsp_ready = 1'b0;
		slow = 1'b0;
		rly = '0;
		cmd = '0;
		slot_present = 2'h1;
		slot_model = {16'h5678, 16'h1234};
		meas_mask = ~(128'h1 << 7'h45);
		tick(12);
		sys_rst = 1'b0;
		t_interval();
		t_relay();
		t_lists();
		t_option();
		t_count();
		wrap_up();
	end
	initial begin
		#400000;
		error_cnt++;
		wrap_up();
	end
endmodule
